// >>> rtl/ffs_consts.svh
// Clock, timing counts, thresholds and gain of the fault supervisor
// Assumes a 250 MHz core clock
`ifndef FFS_CONSTS_SVH
`define FFS_CONSTS_SVH
`define FFS_CLK_MHZ 250
`define FFS_OPP_QUAL_MS 160
`define FFS_RECOVERY_MS 1500
`define FFS_OPP_QUAL_CYC (`FFS_OPP_QUAL_MS * 1000 * `FFS_CLK_MHZ)
`define FFS_RECOVERY_CYC (`FFS_RECOVERY_MS * 1000 * `FFS_CLK_MHZ)
`define FFS_CSF_LONG_NS 2000
`define FFS_CSF_SHORT_NS 1000
`define FFS_CSF_LONG_CYC ((`FFS_CSF_LONG_NS * `FFS_CLK_MHZ) / 1000)
`define FFS_CSF_SHORT_CYC ((`FFS_CSF_SHORT_NS * `FFS_CLK_MHZ) / 1000)
`define FFS_HVG_SETTLE_NS 10000
`define FFS_HVG_SETTLE_CYC ((`FFS_HVG_SETTLE_NS * `FFS_CLK_MHZ) / 1000)
`define FFS_PULSE_QUAL 3
`define FFS_OPP_TOP_MV 600
`define FFS_PCL_MV 800
`define FFS_OCP_MV 1200
`define FFS_LINE_COMP_GAIN 16
`endif

// >>> rtl/ffs_pkg.sv
// Types shared by the fault supervisor files
// Assumes ffs_consts.svh is compiled alongside
package ffs_pkg;
  typedef enum logic [3:0] {
    FFS_RUN = 4'b0001,
    FFS_PINCHK = 4'b0010,
    FFS_HOLD = 4'b0100,
    FFS_LOCKOUT = 4'b1000
  } ffs_state_e;
  typedef logic [31:0] ffs_cnt_t;
  typedef logic [11:0] ffs_mv_t;
endpackage

// >>> rtl/ffs_pulse_qual.sv
// Counts consecutive qualifying low-side pulses, fires at three
// Assumes pulseEnd is a one-cycle strobe on core_clk
`timescale 1ns/1ns
`include "ffs_consts.svh"
module ffs_pulse_qual (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic pulseEnd,
  input wire logic seen,
  output logic hit
);
  import ffs_pkg::*;
  logic [1:0] count;
  logic [1:0] next_count;
  always_comb begin
    next_count = count;
    if (clear) begin
      next_count = 2'h0;
    end else if (pulseEnd) begin
      // Any clean pulse breaks the run
      if (!seen) begin
        next_count = 2'h0;
      end else if (count != 2'(`FFS_PULSE_QUAL)) begin
        next_count = count + 2'h1;
      end
    end
  end
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      count <= 2'h0;
    end else begin
      count <= next_count;
    end
  end
  assign hit = (count == 2'(`FFS_PULSE_QUAL));
  qual_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    pulseEnd && !seen && !clear |=> count == 2'h0) else $error("pulse run not cleared");
endmodule

// >>> rtl/ffs_supervisor.sv
// Fault supervisor of an active-clamp flyback controller
// Assumes analog comparators and pin strobes arrive asynchronous; all are synchronised here
// ----------------------------------------
// How it works
// - Peak sense above over-power curve starts a 160 ms qualification timer.
// - Over-power held 160 ms unbroken stops switching and starts 1.5 s hold.
// - Line compensation current out of sense pin equals line current over gain.
// - Over-power curve tops out at 0.6 V at minimum bulk voltage.
// - Commanded peak level clamped at 0.8 V, soft start included.
// - At supply turn-off, over-power or low aux pin starts 1.5 s hold at once.
// - Sense over 1.2 V in window three pulses running stops switching, starts hold.
// - During hold no gate pulses; restart at first turn-off after timeout.
// - Over-temperature forces lockout cycles, repeated while still hot.
// - Switch select high: first pulse over 2 us flags sense short, immediate hold.
// - Switch select low: limit 2 us with large dead-time resistor, else 1 us.
// - Gate bias pin below 12 V after 10 us at turn-on means open; lockout.
// - Sense pin over 1.2 V three pulses running means open; start hold.
// - Gate bias over 13.8 V three pulses running forces one lockout.
// ----------------------------------------
`timescale 1ns/1ns
`include "ffs_consts.svh"
module ffs_supervisor #(
  parameter int unsigned OPP_QUAL_CYC = `FFS_OPP_QUAL_CYC,
  parameter int unsigned RECOVERY_CYC = `FFS_RECOVERY_CYC
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic supplyOn,
  input wire logic supplyOff,
  input wire logic lowSideGatePulse,
  input wire logic peakAboveOpp,
  input wire logic senseAboveOcp,
  input wire logic senseWindow,
  input wire logic auxPinBelowLimit,
  input wire logic hvgBelowLimit,
  input wire logic hvgOverVolt,
  input wire logic deadTimePinShort,
  input wire logic deadTimePinOpen,
  input wire logic deadTimeResHigh,
  input wire logic zeroVoltPinShort,
  input wire logic zeroVoltPinOpen,
  input wire logic overTemp,
  input wire logic switchTypeSi,
  input wire logic [11:0] lineSenseCurrent,
  input wire logic [11:0] peakCmd,
  output logic gateEnable,
  output logic runOut,
  output logic lockoutReq,
  output logic faultHold,
  output logic pinForceLow,
  output logic [11:0] lineCompCurrent,
  output logic [11:0] peakCmdClamped,
  output logic [11:0] oppTopLevel
);
  import ffs_pkg::*;
  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  localparam int NIN = 16;
  logic [NIN-1:0] rawIn;
  logic [NIN-1:0] meta;
  logic [NIN-1:0] syncd;
  assign rawIn = {supplyOn, supplyOff, lowSideGatePulse, peakAboveOpp, senseAboveOcp, senseWindow,
                  auxPinBelowLimit, hvgBelowLimit, hvgOverVolt, deadTimePinShort, deadTimePinOpen,
                  deadTimeResHigh, zeroVoltPinShort, zeroVoltPinOpen, overTemp, switchTypeSi};
  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi++) begin : g_sync
      always_ff @(posedge core_clk) begin
        if (!rst_n) begin
          meta[gi] <= 1'b0;
          syncd[gi] <= 1'b0;
        end else begin
          meta[gi] <= rawIn[gi];
          syncd[gi] <= meta[gi];
        end
      end
    end
  endgenerate
  logic sOn, sOff, sPulse, sOpp, sOcp, sWin, sAuxLow, sHvgLow, sHvgOv;
  logic sDtShort, sDtOpen, sDtHigh, sZvShort, sZvOpen, sHot, sSi;
  assign {sOn, sOff, sPulse, sOpp, sOcp, sWin, sAuxLow, sHvgLow, sHvgOv,
          sDtShort, sDtOpen, sDtHigh, sZvShort, sZvOpen, sHot, sSi} = syncd;
  // Straps are synchronised too; they settle long before the first pulse, so latency costs nothing
  // ----------------------------------------
  // Analog command path
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      lineCompCurrent <= 12'h000;
      peakCmdClamped <= 12'h000;
      oppTopLevel <= 12'h000;
    end else begin
      lineCompCurrent <= 12'(lineSenseCurrent / `FFS_LINE_COMP_GAIN);
      peakCmdClamped <= (peakCmd > 12'(`FFS_PCL_MV)) ? 12'(`FFS_PCL_MV) : peakCmd;
      oppTopLevel <= 12'(`FFS_OPP_TOP_MV);
    end
  end
  // ----------------------------------------
  // Pulse edges and per-pulse flags
  // ----------------------------------------
  logic pulseDly, pulseEnd, pulseStart, ocpSeen, hvgSeen, firstPulse;
  logic [11:0] onTime;
  logic next_ocpSeen, next_hvgSeen, next_firstPulse;
  logic [11:0] next_onTime;
  ffs_state_e state, next_state;
  assign pulseEnd = pulseDly && !sPulse;
  assign pulseStart = sPulse && !pulseDly;
  always_comb begin
    next_ocpSeen = ocpSeen;
    next_hvgSeen = hvgSeen;
    next_onTime = onTime;
    next_firstPulse = firstPulse;
    if (pulseStart) begin
      next_ocpSeen = 1'b0;
      next_hvgSeen = 1'b0;
      next_onTime = 12'h000;
    end else if (sPulse && onTime != 12'hfff) begin
      next_onTime = onTime + 12'h001;
    end
    if (sOcp && sWin) begin
      next_ocpSeen = 1'b1;
    end
    if (sHvgOv && sPulse) begin
      next_hvgSeen = 1'b1;
    end
    if (pulseEnd) begin
      next_firstPulse = 1'b0;
    end
    if (state != FFS_RUN) begin
      next_firstPulse = 1'b1;
    end
  end
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pulseDly <= 1'b0;
      ocpSeen <= 1'b0;
      hvgSeen <= 1'b0;
      onTime <= 12'h000;
      firstPulse <= 1'b1;
    end else begin
      pulseDly <= sPulse;
      ocpSeen <= next_ocpSeen;
      hvgSeen <= next_hvgSeen;
      onTime <= next_onTime;
      firstPulse <= next_firstPulse;
    end
  end
  logic qualClear, ocpHit, hvgHit;
  assign qualClear = (state != FFS_RUN);
  ffs_pulse_qual u_ocp_qual (
    .core_clk(core_clk), .rst_n(rst_n), .clear(qualClear),
    .pulseEnd(pulseEnd), .seen(ocpSeen), .hit(ocpHit)
  );
  ffs_pulse_qual u_hvg_qual (
    .core_clk(core_clk), .rst_n(rst_n), .clear(qualClear),
    .pulseEnd(pulseEnd), .seen(hvgSeen), .hit(hvgHit)
  );
  logic [11:0] csfLimit;
  logic csShort;
  assign csfLimit = (sSi || sDtHigh) ? 12'(`FFS_CSF_LONG_CYC) : 12'(`FFS_CSF_SHORT_CYC);
  // onTime still holds the previous pulse's length in the start cycle, so that cycle is skipped
  assign csShort = firstPulse && sPulse && !pulseStart && (onTime >= csfLimit);
  // ----------------------------------------
  // Fault sequencer
  // ----------------------------------------
  ffs_cnt_t oppCnt, next_oppCnt, timer, next_timer;
  logic timeoutDone, next_timeoutDone, lockout, next_lockout;
  always_comb begin
    next_state = state;
    next_timer = timer;
    next_timeoutDone = timeoutDone;
    next_lockout = 1'b0;
    next_oppCnt = 32'h0000_0000;
    unique case (state)
      FFS_PINCHK: begin
        next_timer = timer + 32'h0000_0001;
        if (sDtShort || sDtOpen || sZvShort || sZvOpen) begin
          next_state = FFS_LOCKOUT;
        end else if (timer >= 32'(`FFS_HVG_SETTLE_CYC)) begin
          next_state = sHvgLow ? FFS_LOCKOUT : FFS_RUN;
        end
      end
      FFS_RUN: begin
        next_oppCnt = sOpp ? oppCnt + 32'h0000_0001 : 32'h0000_0000;
        if (ocpHit || csShort || (sOpp && oppCnt >= OPP_QUAL_CYC - 1) ||
            (sOff && (sOpp || sAuxLow))) begin
          next_state = FFS_HOLD;
          next_timer = 32'h0000_0000;
          next_timeoutDone = 1'b0;
        end else if (hvgHit || sHot || sOff) begin
          next_state = FFS_LOCKOUT;
        end
      end
      FFS_HOLD: begin
        // Supply keeps cycling; only the turn-off after timeout releases
        if (timer >= RECOVERY_CYC - 1) begin
          next_timeoutDone = 1'b1;
        end else begin
          next_timer = timer + 32'h0000_0001;
        end
        if (timeoutDone && sOff) begin
          next_state = FFS_LOCKOUT;
        end
      end
      FFS_LOCKOUT: begin
        next_lockout = 1'b1;
        if (sOn && !sHot) begin
          next_state = FFS_PINCHK;
          next_timer = 32'h0000_0000;
        end
      end
      default: next_state = FFS_LOCKOUT;
    endcase
  end
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state <= FFS_LOCKOUT;
      timer <= 32'h0000_0000;
      oppCnt <= 32'h0000_0000;
      timeoutDone <= 1'b0;
      lockout <= 1'b0;
    end else begin
      state <= next_state;
      timer <= next_timer;
      oppCnt <= next_oppCnt;
      timeoutDone <= next_timeoutDone;
      lockout <= next_lockout;
    end
  end
  assign gateEnable = (state == FFS_RUN);
  assign runOut = (state == FFS_RUN);
  assign faultHold = (state == FFS_HOLD);
  assign lockoutReq = lockout || faultHold;
  assign pinForceLow = (state == FFS_PINCHK);
  hold_no_gate_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    state == FFS_HOLD && !timeoutDone |=> state == FFS_HOLD && !gateEnable) else $error("hold left early");
  opp_fire_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    state == FFS_RUN && sOpp && oppCnt >= OPP_QUAL_CYC - 1 |=> state == FFS_HOLD) else $error("opp not held");
  opp_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    state == FFS_RUN && !sOpp |=> oppCnt == 0) else $error("opp timer kept");
  short_fire_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    state == FFS_RUN && sOff && sAuxLow |=> state == FFS_HOLD) else $error("short not held");
  ocp_fire_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    state == FFS_RUN && ocpHit |=> !runOut) else $error("ocp kept running");
  clamp_peak_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    peakCmdClamped <= 12'(`FFS_PCL_MV)) else $error("peak over clamp");
  hot_lock_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    state == FFS_LOCKOUT && sHot |=> state == FFS_LOCKOUT) else $error("hot restart");
  pin_fault_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    state == FFS_PINCHK && (sDtShort || sZvOpen) |=> state == FFS_LOCKOUT) else $error("pin fault missed");
  cs_short_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    state == FFS_RUN && csShort && !ocpHit |=> faultHold) else $error("cs short missed");
endmodule

// >>> bench/ffs_stage_model.sv
// Power stage and sense comparators as seen by the fault supervisor
// Assumes the bench sets the fault knobs at falling clock edges
`timescale 1ns/1ns
module ffs_stage_model (
  input wire logic core_clk,
  input wire logic gateEnable,
  input wire logic [9:0] pulseLen,
  input wire logic ocpMode,
  input wire logic hvgOvMode,
  output logic lowSideGatePulse,
  output logic senseAboveOcp,
  output logic senseWindow,
  output logic hvgOverVolt
);
  int phase = 0;
  initial begin
    lowSideGatePulse = 1'b0;
    senseAboveOcp = 1'b0;
    senseWindow = 1'b0;
    hvgOverVolt = 1'b0;
  end
  // No gate drive without enable; comparators see a quiet stage then
  always @(negedge core_clk) begin
    phase <= (!gateEnable || phase >= pulseLen + 10) ? 0 : phase + 1;
    lowSideGatePulse <= gateEnable && phase < pulseLen;
    senseWindow <= gateEnable && phase > 1 && phase < pulseLen + 4;
    senseAboveOcp <= gateEnable && ocpMode && phase < pulseLen;
    hvgOverVolt <= gateEnable && hvgOvMode && phase < pulseLen;
  end
endmodule

// >>> bench/test_flyback_fault_supervisor.sv
// Bench for the flyback fault supervisor, one task per scenario
// Assumes the stage model makes gate pulses and sense comparator levels
`timescale 1ns/1ns
module test_flyback_fault_supervisor;
  // ----------------------------------------
  // Stimulus and design
  // ----------------------------------------
  localparam int QUAL = 50;
  localparam int RECOV = 200;
  localparam int GE = 0, FH = 1, LR = 2, PF = 3;
  logic core_clk = 1'b0, rst_n = 1'b0, supplyOn = 1'b0, supplyOff = 1'b0, peakAboveOpp = 1'b0;
  logic auxPinBelowLimit = 1'b0, overTemp = 1'b0, switchTypeSi = 1'b0, deadTimeResHigh = 1'b0;
  logic ocpMode = 1'b0, hvgOvMode = 1'b0;
  logic [4:0] pinFault = 5'h00;
  logic [9:0] pulseLen = 10'h00A;
  logic [11:0] lineSenseCurrent = 12'h0000, peakCmd = 12'h0000;
  logic lowSideGatePulse, senseAboveOcp, senseWindow, hvgOverVolt;
  logic gateEnable, runOut, lockoutReq, faultHold, pinForceLow;
  logic [11:0] lineCompCurrent, peakCmdClamped, oppTopLevel;
  int n_errors = 0, cmp_count = 0;
  always #2 core_clk = ~core_clk;
  ffs_supervisor #(.OPP_QUAL_CYC(QUAL), .RECOVERY_CYC(RECOV)) i_dut (
    .core_clk, .rst_n, .supplyOn, .supplyOff, .lowSideGatePulse, .peakAboveOpp, .senseAboveOcp,
    .senseWindow, .auxPinBelowLimit, .hvgBelowLimit(pinFault[4]), .hvgOverVolt,
    .deadTimePinShort(pinFault[0]), .deadTimePinOpen(pinFault[1]), .deadTimeResHigh,
    .zeroVoltPinShort(pinFault[2]), .zeroVoltPinOpen(pinFault[3]), .overTemp, .switchTypeSi,
    .lineSenseCurrent, .peakCmd, .gateEnable, .runOut, .lockoutReq, .faultHold, .pinForceLow,
    .lineCompCurrent, .peakCmdClamped, .oppTopLevel);
  ffs_stage_model i_stage (.core_clk, .gateEnable, .pulseLen, .ocpMode, .hvgOvMode,
    .lowSideGatePulse, .senseAboveOcp, .senseWindow, .hvgOverVolt);
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [11:0] got, input logic [11:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic cycles(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  function automatic logic pick(input int sel);
    case (sel)
      GE: return gateEnable;
      FH: return faultHold;
      LR: return lockoutReq;
      default: return pinForceLow;
    endcase
  endfunction
  // Bounded wait so a stuck state shows up as a mismatch, not a hang
  task automatic await(input int sel, input int limit, input string what);
    int k;
    k = 0;
    while (pick(sel) !== 1'b1 && k < limit) begin
      cycles(1);
      k++;
    end
    check(pick(sel), 1'b1, what);
  endtask
  task automatic reset_dut();
    rst_n = 1'b0;
    supplyOn = 1'b0;
    peakAboveOpp = 1'b0;
    auxPinBelowLimit = 1'b0;
    pinFault = 5'h00;
    overTemp = 1'b0;
    ocpMode = 1'b0;
    hvgOvMode = 1'b0;
    cycles(3);
    rst_n = 1'b1;
    cycles(1);
    check({gateEnable, faultHold, pinForceLow}, 0, "idle after reset");
  endtask
  task automatic start();
    supplyOn = 1'b1;
    await(PF, 10, "pins forced in check");
    // The lockout request is registered and trails the state by one cycle
    cycles(1);
    check(lockoutReq, 0, "no lockout in check");
    await(GE, 2700, "switching after check");
    check(runOut, 1, "run high");
  endtask
  task automatic supply_drop();
    supplyOn = 1'b0;
    supplyOff = 1'b1;
    cycles(4);
    supplyOff = 1'b0;
    cycles(4);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_static();
    logic [11:0] v [3];
    int i;
    v = '{12'h0320, 12'h0321, 12'h0FFF};
    for (i = 0; i < 3; i++) begin
      peakCmd = v[i];
      lineSenseCurrent = ~v[i];
      cycles(3);
      check(peakCmdClamped, (v[i] > 12'h0320) ? 12'h0320 : v[i], "peak clamp");
      check(lineCompCurrent, (~v[i]) >> 4, "line comp");
    end
    check(oppTopLevel, 12'h0258, "opp top");
    $display("test static done");
  endtask
  task automatic t_pins();
    int i;
    int k;
    for (i = 0; i < 5; i++) begin
      reset_dut();
      pinFault = 5'h01 << i;
      supplyOn = 1'b1;
      await(PF, 10, "pin check entered");
      // Wait for the check to end, then let the registered request follow
      k = 0;
      while (pinForceLow === 1'b1 && k < 2700) begin
        cycles(1);
        k++;
      end
      cycles(1);
      check(lockoutReq, 1, "pin fault lockout");
      check(gateEnable, 0, "no switching on pin fault");
    end
    $display("test pins done");
  endtask
  task automatic t_opp();
    reset_dut();
    start();
    peakAboveOpp = 1'b1;
    cycles(QUAL - 10);
    peakAboveOpp = 1'b0;
    cycles(4);
    peakAboveOpp = 1'b1;
    cycles(QUAL - 10);
    check(faultHold, 0, "opp timer restarted");
    await(FH, 20, "opp hold");
    check(gateEnable, 0, "no switching in hold");
    peakAboveOpp = 1'b0;
    supply_drop();
    check(faultHold, 1, "hold before timeout");
    cycles(RECOV);
    supply_drop();
    check({faultHold, lockoutReq}, 1, "lockout after timeout");
    start();
    $display("test opp done");
  endtask
  task automatic t_ocp();
    reset_dut();
    start();
    ocpMode = 1'b1;
    repeat (2) @(negedge lowSideGatePulse);
    ocpMode = 1'b0;
    repeat (2) @(negedge lowSideGatePulse);
    ocpMode = 1'b1;
    repeat (2) @(negedge lowSideGatePulse);
    check(faultHold, 0, "ocp run broken");
    await(FH, 40, "ocp hold");
    check({runOut, gateEnable}, 0, "run low");
    $display("test ocp done");
  endtask
  task automatic t_hvg_temp();
    reset_dut();
    start();
    hvgOvMode = 1'b1;
    await(LR, 60, "gate bias over-voltage lockout");
    check({faultHold, gateEnable}, 0, "lockout, not hold");
    reset_dut();
    start();
    overTemp = 1'b1;
    await(LR, 10, "over-temperature lockout");
    supply_drop();
    supplyOn = 1'b1;
    cycles(2700);
    check({gateEnable, lockoutReq}, 1, "still hot, lockout again");
    overTemp = 1'b0;
    start();
    $display("test hvg temp done");
  endtask
  task automatic t_scp();
    int i;
    for (i = 0; i < 3; i++) begin
      reset_dut();
      start();
      auxPinBelowLimit = (i == 0);
      peakAboveOpp = (i == 1);
      cycles(4);
      supply_drop();
      check(faultHold, i < 2, "hold at supply drop");
      check(lockoutReq, 1, "lockout request");
    end
    $display("test scp done");
  endtask
  task automatic t_first();
    logic [9:0] len [5];
    logic [4:0] si, res, hold;
    int i;
    len = '{10'h1FE, 10'h1EA, 10'h1EA, 10'h104, 10'h0F0};
    si = 5'h03;
    res = 5'h04;
    hold = 5'h09;
    for (i = 0; i < 5; i++) begin
      switchTypeSi = si[i];
      deadTimeResHigh = res[i];
      pulseLen = len[i];
      reset_dut();
      start();
      cycles(len[i] + 20);
      check(faultHold, hold[i], "first pulse limit");
    end
    pulseLen = 10'h00A;
    switchTypeSi = 1'b0;
    $display("test first pulse done");
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #(4 * 80000);
    n_errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    final_report();
  end
  initial begin
    reset_dut();
    t_static();
    t_pins();
    t_opp();
    t_ocp();
    t_hvg_temp();
    t_scp();
    t_first();
    final_report();
  end
endmodule
